// ### hdl/tsr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tsr_regs #(
	parameter logic [7:0] MAKER_CODE = 8'h5A,  // arbitrary value
	parameter logic [7:0] REV_CODE   = 8'h3C   // arbitrary value
) (
	// clock, reset, enable
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	// byte port from the serial engine
	input  wire logic        cmd_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [7:0]  wdata_i,
	output var  logic [7:0]  rd_data_o,
	// conversion results and analog status, other domain
	input  wire logic        conv_tog_i,
	input  wire logic [10:0] loc_temp_i,
	input  wire logic [12:0] rem_temp_i,
	input  wire logic        busy_i,
	input  wire logic        fault_i,
	input  wire logic        detect_i,
	input  wire logic        not_ready_i,
	// controls to the converter and pins
	output var  logic        conv_start_o,
	output var  logic        standby_o,
	output var  logic [1:0]  rate_o,
	output var  logic        filter_en_o,
	output var  logic        diode_model_o,
	output var  logic [10:0] offset_o,
	output var  logic        shared_addr_alarm_pin_o,
	output var  logic        overtemp_alarm_o,
	output var  logic        crit_alarm_o
);
	import tsr_pkg::*;

	tsr_state_t st_r;
	tsr_state_t st_nxt;
	tsr_sync_if sif ();

	// the done toggle and status inputs pass the two-stage synchroniser; the temperature buses do not
	assign sif.raw = {conv_tog_i, busy_i, fault_i, detect_i, not_ready_i};

	tsr_sync #(.STAGES(2)) u_sync (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.ce_i    (ce_i),
		.sif     (sif)
	);

	logic       s_busy;
	logic       s_fault;
	logic       s_det;
	logic       s_nrdy;
	assign s_busy  = sif.lvl[3];
	assign s_fault = sif.lvl[2];
	assign s_det   = sif.lvl[1];
	assign s_nrdy  = sif.lvl[0];

	// place a 5-bit fraction in the byte per filter setting
	function automatic logic [7:0] frac_fmt(input logic [4:0] f, input logic filt);
		frac_fmt = filt ? {f, 3'h0} : {f[4:2], 5'h00}; // R4 R5
	endfunction

	// above the limit
	function automatic logic hot(input logic [9:0] t, input logic [9:0] lim);
		hot = $signed(t) > $signed(lim);
	endfunction

	// below limit minus hysteresis
	function automatic logic cool(input logic [9:0] t, input logic [9:0] lim,
		input logic [4:0] hy);
		cool = $signed(t) < ($signed(lim) - $signed({5'h00, hy}));
	endfunction

	// derived readings
	logic       filt;
	logic [7:0] sint;
	logic [4:0] sfrac;
	logic [7:0] uint;
	logic [4:0] ufrac;
	logic [4:0] lfrac;
	logic [2:0][4:0] live;
	logic [9:0] lt;
	logic [9:0] rt;

	always_comb begin
		filt  = st_r.filt_en;
		lfrac = {st_r.loc[2:0], 2'h0};
		// unsigned form, full scale on a fault
		uint  = s_fault ? 8'hFF : st_r.rem[12:5]; // R16
		ufrac = s_fault ? FRAC_FULL : st_r.rem[4:0];
		// signed form saturates above its range
		if (s_fault) begin
			sint  = SINT_FAULT; // R3
			sfrac = 5'h00;
		end else if (st_r.rem[12]) begin
			sint  = SINT_MAX;
			sfrac = FRAC_FULL;
		end else begin
			sint  = st_r.rem[12:5];
			sfrac = st_r.rem[4:0];
		end
		live = {ufrac, sfrac, lfrac};
		// compare values come from the conversion that is arriving, not the stored one
		lt   = {{2{loc_temp_i[10]}}, loc_temp_i[10:3]};
		rt   = {2'h0, s_fault ? 8'hFF : rem_temp_i[12:5]};
	end

	// pick the fraction, frozen or live, for a channel
	function automatic logic [4:0] pick(input tsr_state_t s, input logic [2:0][4:0] lv,
		input tsr_ch_t c);
		pick = s.lock[c] ? s.frz[c] : lv[c];
	endfunction

	// next-state logic
	always_comb begin
		logic any_os;
		logic any_crit;
		logic both_cool_os;
		logic both_cool_crit;
		logic [9:0] llim;
		any_os         = 1'b0;
		any_crit       = 1'b0;
		both_cool_os   = 1'b0;
		both_cool_crit = 1'b0;
		llim           = {3'h0, st_r.loc_lim};
		st_nxt         = st_r;
		st_nxt.start   = 1'b0;

		// command byte sets the pointer, which otherwise holds
		if (cmd_i) begin
			st_nxt.ptr = wdata_i; // R19
		end else if (wr_i) begin
			// data byte writes at the pointer; others are ignored
			case (st_r.ptr) // R20
				A_CFG1, A_CFG1_ALT: st_nxt.cfg1 = wdata_i & CFG1_WMSK; // R8
				A_RATE, A_RATE_ALT: st_nxt.rate = wdata_i[1:0]; // R9
				A_ROS, A_ROS_ALT:   st_nxt.ros = wdata_i; // R10
				A_RCRIT:            st_nxt.rcrit = wdata_i; // R10
				A_LOC_LIM:          st_nxt.loc_lim = wdata_i[6:0]; // R11
				A_HYST:             st_nxt.hyst = wdata_i[4:0];
				A_OFF_HI:           st_nxt.off_hi = wdata_i; // R12
				A_OFF_LO:           st_nxt.off_lo = wdata_i[7:5]; // R12
				A_CFG2: begin
					st_nxt.cfg2    = wdata_i & CFG2_WMSK; // R13
					st_nxt.filt_en = &wdata_i[CFG2_FILTH:CFG2_FILTL]; // R4 R5
				end
				A_ONESHOT: begin
					st_nxt.start = st_r.cfg1[CFG1_STBY]; // R7
				end
				default: begin
				end
			endcase
		end

		// register reads with fraction freezing
		if (rd_i && !cmd_i) begin
			case (st_r.ptr)
				A_LOC_INT: begin
					st_nxt.rdat                = st_r.loc[10:3]; // R1
					st_nxt.lock[TSR_CH_LOC]    = 1'b1; // R17
					st_nxt.frz[TSR_CH_LOC]     = lfrac;
				end
				A_REM_SINT: begin
					st_nxt.rdat                = sint; // R3
					st_nxt.lock[TSR_CH_RSGN]   = 1'b1; // R17
					st_nxt.frz[TSR_CH_RSGN]    = sfrac;
				end
				A_REM_UINT: begin
					st_nxt.rdat                = uint; // R16
					st_nxt.lock[TSR_CH_RUNS]   = 1'b1; // R17
					st_nxt.frz[TSR_CH_RUNS]    = ufrac;
				end
				A_LOC_FRAC: begin
					st_nxt.rdat = frac_fmt(pick(st_r, live, TSR_CH_LOC), 1'b0); // R2
					st_nxt.lock[TSR_CH_LOC]  = 1'b0; // R17
				end
				A_REM_SFRAC: begin
					st_nxt.rdat = frac_fmt(pick(st_r, live, TSR_CH_RSGN), filt);
					st_nxt.lock[TSR_CH_RSGN] = 1'b0; // R17
				end
				A_REM_UFRAC: begin
					st_nxt.rdat = frac_fmt(pick(st_r, live, TSR_CH_RUNS), filt); // R16
					st_nxt.lock[TSR_CH_RUNS] = 1'b0; // R17
				end
				A_STAT1: begin
					st_nxt.rdat = '0; // R14
					st_nxt.rdat[ST1_BUSY]  = s_busy;
					st_nxt.rdat[ST1_ROS]   = st_r.ros_hot;
					st_nxt.rdat[ST1_FAULT] = s_fault;
					st_nxt.rdat[ST1_RCRIT] = st_r.rcrit_hot;
					st_nxt.rdat[ST1_LOC]   = st_r.loc_hot;
				end
				A_STAT2: begin
					st_nxt.rdat = '0; // R15
					st_nxt.rdat[ST2_NRDY] = s_nrdy;
					st_nxt.rdat[ST2_DET]  = s_det;
				end
				A_CFG1, A_CFG1_ALT: st_nxt.rdat = st_r.cfg1; // R6
				A_RATE, A_RATE_ALT: st_nxt.rdat = {6'h00, st_r.rate}; // R6
				A_ROS, A_ROS_ALT:   st_nxt.rdat = st_r.ros;
				A_RCRIT:            st_nxt.rdat = st_r.rcrit;
				A_LOC_LIM:          st_nxt.rdat = {1'b0, st_r.loc_lim}; // R6
				A_HYST:             st_nxt.rdat = {3'h0, st_r.hyst}; // R6
				A_OFF_HI:           st_nxt.rdat = st_r.off_hi;
				A_OFF_LO:           st_nxt.rdat = {st_r.off_lo, 5'h00}; // R6
				A_CFG2:             st_nxt.rdat = st_r.cfg2 | CFG2_ONES; // R6
				A_MAKER:            st_nxt.rdat = MAKER_CODE;
				A_REV:              st_nxt.rdat = REV_CODE;
				default:            st_nxt.rdat = 8'h00; // R20
			endcase
		end

		// new conversion: capture results, update flags and alarms
		if (sif.done) begin
			st_nxt.loc       = loc_temp_i;
			st_nxt.rem       = rem_temp_i;
			st_nxt.ros_hot   = hot(rt, {2'h0, st_r.ros});
			st_nxt.rcrit_hot = hot(rt, {2'h0, st_r.rcrit});
			st_nxt.loc_hot   = hot(lt, llim); // R11
			any_os = (st_nxt.ros_hot & ~st_r.cfg1[CFG1_ROSM])
				| (st_nxt.loc_hot & ~st_r.cfg1[CFG1_LOSM])
				| (s_fault & ~st_r.cfg2[CFG2_OSFM]);
			any_crit = (st_nxt.rcrit_hot & ~st_r.cfg1[CFG1_RCRITM])
				| (st_nxt.loc_hot & ~st_r.cfg1[CFG1_LCRITM])
				| (s_fault & ~st_r.cfg2[CFG2_CRFM]);
			both_cool_os = cool(lt, llim, st_r.hyst)
				& cool(rt, {2'h0, st_r.ros}, st_r.hyst);
			both_cool_crit = cool(lt, llim, st_r.hyst)
				& cool(rt, {2'h0, st_r.rcrit}, st_r.hyst);
			// set on any unmasked hot channel or unmasked fault, clear only with both channels cool
			if (any_os) begin
				st_nxt.os_alarm = 1'b1;
			end else if (both_cool_os) begin
				st_nxt.os_alarm = 1'b0; // R18
			end
			if (any_crit) begin
				st_nxt.crit_alarm = 1'b1;
			end else if (both_cool_crit) begin
				st_nxt.crit_alarm = 1'b0; // R18
			end
		end
	end

	// state register; enable low freezes everything
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st_r         <= '0;
			st_r.ptr     <= RST_PTR; // R19
			st_r.cfg1    <= RST_CFG1; // R8
			st_r.rate    <= RST_RATE; // R9
			st_r.ros     <= RST_ROS; // R10
			st_r.rcrit   <= RST_RCRIT; // R10
			st_r.loc_lim <= RST_LOC; // R11
			st_r.hyst    <= RST_HYST;
			st_r.cfg2    <= RST_CFG2 & CFG2_WMSK; // R13
			st_r.filt_en <= &RST_CFG2[CFG2_FILTH:CFG2_FILTL];
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign rd_data_o               = st_r.rdat;
	assign conv_start_o            = st_r.start;
	assign standby_o               = st_r.cfg1[CFG1_STBY];
	assign rate_o                  = st_r.rate;
	assign filter_en_o             = st_r.filt_en;
	assign diode_model_o           = st_r.cfg2[CFG2_MODEL];
	assign offset_o                = {st_r.off_hi, st_r.off_lo}; // R12
	assign shared_addr_alarm_pin_o = st_r.cfg2[CFG2_PIN];
	assign overtemp_alarm_o        = st_r.os_alarm;
	assign crit_alarm_o            = st_r.crit_alarm;

	// checks
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_rd(logic [7:0] a);
		rd_i && !cmd_i && ce_i && st_r.ptr == a;
	endsequence
	sequence s_wr(logic [7:0] a);
		wr_i && !cmd_i && ce_i && st_r.ptr == a;
	endsequence

	property p_oneshot;
		s_wr(A_ONESHOT) |=> conv_start_o == $past(standby_o);
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot start wrong"); // R7

	property p_reset_vals;
		$rose(rst_n_i) |-> st_r.ptr == RST_PTR && st_r.cfg1 == RST_CFG1
			&& rate_o == RST_RATE && st_r.ros == RST_ROS && st_r.rcrit == RST_RCRIT;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset value"); // R19

	property p_rate_alias;
		s_wr(A_RATE_ALT) |=> rate_o == $past(wdata_i[1:0]);
	endproperty
	a_rate_alias: assert property (p_rate_alias) else $error("rate alias write lost"); // R9

	property p_unlisted;
		s_rd(8'h05) |=> rd_data_o == 8'h00;
	endproperty
	a_unlisted: assert property (p_unlisted) else $error("unlisted read nonzero"); // R20

	property p_freeze;
		s_rd(A_LOC_FRAC) ##0 st_r.lock[TSR_CH_LOC]
			|=> rd_data_o[7:5] == $past(st_r.frz[TSR_CH_LOC][4:2]);
	endproperty
	a_freeze: assert property (p_freeze) else $error("fraction not frozen"); // R17

	property p_unlock;
		s_rd(A_LOC_FRAC) |=> !st_r.lock[TSR_CH_LOC];
	endproperty
	a_unlock: assert property (p_unlock) else $error("fraction stays locked"); // R17

	property p_refreeze;
		s_rd(A_LOC_INT) |=> st_r.lock[TSR_CH_LOC]
			&& st_r.frz[TSR_CH_LOC][4:2] == $past(st_r.loc[2:0]);
	endproperty
	a_refreeze: assert property (p_refreeze) else $error("integer read did not refreeze"); // R17

	property p_cfg2_rsvd;
		s_rd(A_CFG2) |=> rd_data_o[7] == 1'b0 && rd_data_o[0] == 1'b1;
	endproperty
	a_cfg2_rsvd: assert property (p_cfg2_rsvd) else $error("reserved bits wrong"); // R6

	property p_filt_off;
		s_rd(A_REM_SFRAC) ##0 !filter_en_o |=> rd_data_o[4:0] == 5'h00;
	endproperty
	a_filt_off: assert property (p_filt_off) else $error("filter-off low bits set"); // R5

	property p_loc_frac;
		s_rd(A_LOC_FRAC) |=> rd_data_o[4:0] == 5'h00;
	endproperty
	a_loc_frac: assert property (p_loc_frac) else $error("local fraction low bits set"); // R2

	property p_alarm_hold;
		overtemp_alarm_o && ce_i && !sif.done |=> overtemp_alarm_o;
	endproperty
	a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped early"); // R18

	property p_ro_write;
		s_wr(A_STAT1) |=> $stable(st_r.cfg1) && $stable(st_r.ros) && $stable(st_r.cfg2);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write changed state"); // R20
endmodule
`default_nettype wire

// ### pkg/tsr_pkg.sv
// Functional notes
// R1: local integer byte at 0x00, two's complement, 1 degree per LSB.
// R2: local fraction at 0x30 uses top three bits; lower five read zero.
// R3: signed remote integer byte at 0x01, two's complement, 1 degree LSB.
// R4: filter on: remote fraction fills top five bits, half down to 1/32.
// R5: filter off: remote fraction fills top three bits, lower five zero.
// R6: unimplemented bits of partly used registers read as zero; the code reads bit 0 of 0xBF as one.
// R7: any write to 0x0F starts one conversion only in standby; not stored.
// R8: first config register, reset 0x00, standby and masks, at 0x03/0x09.
// R9: two-bit conversion rate, reset 0x02, at 0x04 and 0x0A.
// R10: remote overtemp limit reset 0x55, remote critical limit reset 0x6E.
// R11: one 7-bit local limit at 0x20, reset 0x55, shared by both alarms.
// R12: remote offset high 0x11, low 0x12 with 3 bits, both reset zero.
// R13: second config register 0xBF, reset 0x1F: filter, model, masks, pin.
// R14: status one at 0x02: busy, alarm and fault bits, read only.
// R15: status two at 0x33: not-ready and diode-detect bits, read only.
// R16: unsigned remote integer at 0x31, fraction at 0x32.
// R17: integer read freezes its fraction until read; later integer reread refreshes.
// R18: alarm clears only when both channels fall below limit minus hysteresis.
// R19: pointer starts at local integer, then keeps the last command byte.
// R20: writes to read-only or unlisted addresses change nothing; unlisted reads zero.
package tsr_pkg;
	// register offsets
	localparam logic [7:0] A_LOC_INT   = 8'h00;
	localparam logic [7:0] A_REM_SINT  = 8'h01;
	localparam logic [7:0] A_STAT1     = 8'h02;
	localparam logic [7:0] A_CFG1      = 8'h03;
	localparam logic [7:0] A_CFG1_ALT  = 8'h09;
	localparam logic [7:0] A_RATE      = 8'h04;
	localparam logic [7:0] A_RATE_ALT  = 8'h0A;
	localparam logic [7:0] A_ROS       = 8'h07;
	localparam logic [7:0] A_ROS_ALT   = 8'h0D;
	localparam logic [7:0] A_ONESHOT   = 8'h0F;
	localparam logic [7:0] A_REM_SFRAC = 8'h10;
	localparam logic [7:0] A_OFF_HI    = 8'h11;
	localparam logic [7:0] A_OFF_LO    = 8'h12;
	localparam logic [7:0] A_RCRIT     = 8'h19;
	localparam logic [7:0] A_LOC_LIM   = 8'h20;
	localparam logic [7:0] A_HYST      = 8'h21;
	localparam logic [7:0] A_LOC_FRAC  = 8'h30;
	localparam logic [7:0] A_REM_UINT  = 8'h31;
	localparam logic [7:0] A_REM_UFRAC = 8'h32;
	localparam logic [7:0] A_STAT2     = 8'h33;
	localparam logic [7:0] A_CFG2      = 8'hBF;
	localparam logic [7:0] A_MAKER     = 8'hFE;
	localparam logic [7:0] A_REV       = 8'hFF;
	// reset values and writable-bit masks
	localparam logic [7:0] RST_PTR   = 8'h00;
	localparam logic [7:0] RST_CFG1  = 8'h00;
	localparam logic [1:0] RST_RATE  = 2'h2;
	localparam logic [7:0] RST_ROS   = 8'h55;
	localparam logic [7:0] RST_RCRIT = 8'h6E;
	localparam logic [6:0] RST_LOC   = 7'h55;
	localparam logic [4:0] RST_HYST  = 5'h0A;
	localparam logic [7:0] RST_CFG2  = 8'h1F;
	localparam logic [7:0] CFG1_WMSK = 8'h5E;
	localparam logic [7:0] CFG2_WMSK = 8'h7E;
	localparam logic [7:0] CFG2_ONES = 8'h01;
	// field positions
	localparam int CFG1_STBY   = 6;
	localparam int CFG1_RCRITM = 4;
	localparam int CFG1_ROSM   = 3;
	localparam int CFG1_LCRITM = 2;
	localparam int CFG1_LOSM   = 1;
	localparam int CFG2_PIN    = 6;
	localparam int CFG2_OSFM   = 5;
	localparam int CFG2_CRFM   = 4;
	localparam int CFG2_MODEL  = 3;
	localparam int CFG2_FILTH  = 2;
	localparam int CFG2_FILTL  = 1;
	localparam int ST1_BUSY    = 7;
	localparam int ST1_ROS     = 4;
	localparam int ST1_FAULT   = 2;
	localparam int ST1_RCRIT   = 1;
	localparam int ST1_LOC     = 0;
	localparam int ST2_NRDY    = 7;
	localparam int ST2_DET     = 6;
	// fault readings and saturation
	localparam logic [7:0] SINT_FAULT = 8'h80;
	localparam logic [7:0] SINT_MAX   = 8'h7F;
	localparam logic [4:0] FRAC_FULL  = 5'h1F;
	// fraction freeze channels
	typedef enum logic [1:0] {TSR_CH_LOC, TSR_CH_RSGN, TSR_CH_RUNS} tsr_ch_t;
	// register bank state
	typedef struct packed {
		logic [7:0]      ptr;
		logic [7:0]      cfg1;
		logic [1:0]      rate;
		logic [7:0]      ros;
		logic [7:0]      rcrit;
		logic [6:0]      loc_lim;
		logic [4:0]      hyst;
		logic [7:0]      off_hi;
		logic [2:0]      off_lo;
		logic [7:0]      cfg2;
		logic            filt_en;
		logic [10:0]     loc;
		logic [12:0]     rem;
		logic [2:0]      lock;
		logic [2:0][4:0] frz;
		logic            ros_hot;
		logic            rcrit_hot;
		logic            loc_hot;
		logic            os_alarm;
		logic            crit_alarm;
		logic [7:0]      rdat;
		logic            start;
	} tsr_state_t;
endpackage

// ### pkg/tsr_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tsr_sync_if;
	logic [4:0] raw;  // done toggle, busy, fault, detect, not ready
	logic [3:0] lvl;
	logic       done;
	modport sync (input raw, output lvl, output done);
	modport user (output raw, input lvl, input done);
endinterface
`default_nettype wire

// ### hdl/tsr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tsr_sync #(
	parameter int STAGES = 2
) (
	// clock, reset and enable
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	// synchronised signals
	tsr_sync_if.sync  sif
);
	typedef struct packed {
		logic [STAGES-1:0][4:0] sh;
		logic                   tog_d;
	} tsr_sync_st_t;
	tsr_sync_st_t s_r;
	tsr_sync_st_t s_nxt;

	// the edge finder needs a full two-stage chain in front of it
	if (STAGES < 2) begin : g_stage_check
		$error("tsr_sync needs at least two stages");
	end

	// shift chain; the edge finder looks only at the last stage
	always_comb begin
		s_nxt       = s_r;
		s_nxt.sh    = {s_r.sh[STAGES-2:0], sif.raw};
		s_nxt.tog_d = s_r.sh[STAGES-1][4];
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign sif.lvl  = s_r.sh[STAGES-1][3:0];
	assign sif.done = s_r.sh[STAGES-1][4] ^ s_r.tog_d;
endmodule
`default_nettype wire

// ### test/tsr_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// converter stand-in on its own free-running 48 ns clock
module tsr_conv_model (
	// requests from the bench
	input  wire logic        req_i,
	input  wire logic [10:0] loc_v_i,
	input  wire logic [12:0] rem_v_i,
	// results towards the register bank
	output var  logic        tog_o,
	output var  logic [10:0] loc_o,
	output var  logic [12:0] rem_o,
	output var  logic        busy_o
);
	logic lclk = 1'b0;
	logic seen = 1'b0;
	// converter clock, unrelated in phase to the bank clock
	always #24 lclk = ~lclk;
	// a request toggle publishes new results and flips the done toggle
	always @(posedge lclk) begin
		busy_o <= (req_i != seen);
		if (req_i != seen) begin
			seen  <= req_i;
			loc_o <= loc_v_i;
			rem_o <= rem_v_i;
			tog_o <= ~tog_o;
		end
	end
	// idle results before the first conversion
	initial begin
		tog_o = 1'b0;
		loc_o = 11'h000;
		rem_o = 13'h0000;
		busy_o = 1'b0;
	end
endmodule
`default_nettype wire

// ### test/tsr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tsr_regs_tb;
	import tsr_pkg::*;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        cmd = 1'b0, wr = 1'b0, rd = 1'b0, req = 1'b0;
	logic        flt = 1'b0, det = 1'b0, nrdy = 1'b0, ce = 1'b1;
	logic [7:0]  wd = 8'h00;
	logic [10:0] lv = 11'h000;
	logic [12:0] rv = 13'h0000;
	logic [7:0]  rdat, v, d;
	logic        tog, bsy, cst, stby, filt, dmod, pin, osa, cra;
	logic [1:0]  rate;
	logic [10:0] loc, offs, l;
	logic [12:0] rem, r;
	logic [7:0]  sh [256];
	integer      err_count = 0, n_tests = 0, cyc = 0, seed = 19743, starts = 0, i, s0;
	// writable places: write address, read address, live bits, reset value
	logic [7:0]  wa [12] = '{8'h03, 8'h09, 8'h04, 8'h0A, 8'h07, 8'h0D,
		8'h19, 8'h20, 8'h21, 8'h11, 8'h12, 8'hBF};
	logic [7:0]  ra [12] = '{8'h03, 8'h03, 8'h04, 8'h04, 8'h07, 8'h07,
		8'h19, 8'h20, 8'h21, 8'h11, 8'h12, 8'hBF};
	logic [7:0]  mk [12] = '{8'h5E, 8'h5E, 8'h03, 8'h03, 8'hFF, 8'hFF,
		8'hFF, 8'h7F, 8'h1F, 8'hFF, 8'hE0, 8'h7E};
	logic [7:0]  rs [12] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h55, 8'h55,
		8'h6E, 8'h55, 8'h0A, 8'h00, 8'h00, 8'h1F};
	// alarm walk: degrees, expected alarms per step, expected status bits
	logic [7:0]  lt [8] = '{8'h14, 8'h5A, 8'h50, 8'h46, 8'h46, 8'h14, 8'h14, 8'h14};
	logic [7:0]  rt [8] = '{8'h14, 8'h14, 8'h14, 8'h50, 8'h46, 8'h64, 8'h78, 8'h14};
	logic [7:0]  st [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h10, 8'h12, 8'h00};
	logic [7:0]  eo = 8'h6E;
	logic [7:0]  ec = 8'h46;

	tsr_regs dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .cmd_i(cmd), .wr_i(wr),
		.rd_i(rd), .wdata_i(wd), .rd_data_o(rdat), .conv_tog_i(tog), .loc_temp_i(loc),
		.rem_temp_i(rem), .busy_i(bsy), .fault_i(flt), .detect_i(det), .not_ready_i(nrdy),
		.conv_start_o(cst), .standby_o(stby), .rate_o(rate), .filter_en_o(filt),
		.diode_model_o(dmod), .offset_o(offs), .shared_addr_alarm_pin_o(pin),
		.overtemp_alarm_o(osa), .crit_alarm_o(cra));
	tsr_conv_model conv_m (.req_i(req), .loc_v_i(lv), .rem_v_i(rv), .tog_o(tog),
		.loc_o(loc), .rem_o(rem), .busy_o(bsy));

	// clock, hang guard and start-pulse counter
	always #2.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cyc = cyc + 1;
		if (cst === 1'b1) starts = starts + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			tally_and_finish();
		end
	end

	// expected remote fractions
	function automatic logic [7:0] ufrac(input logic [12:0] x, input logic f);
		return f ? {x[4:0], 3'h0} : {x[4:2], 5'h00};
	endfunction
	function automatic logic [7:0] sfrac(input logic [12:0] x, input logic f);
		return x[12] ? (f ? 8'hF8 : 8'hE0) : ufrac(x, f);
	endfunction

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one byte-port strobe held for a single edge
	task op(input logic c, input logic w, input logic rr, input logic [7:0] b);
		@(posedge mclk_i);
		#1;
		{cmd, wr, rd, wd} = {c, w, rr, b};
		@(posedge mclk_i);
		#1;
		{cmd, wr, rd} = 3'b000;
	endtask
	task wreg(input logic [7:0] a, input logic [7:0] b);
		op(1'b1, 1'b0, 1'b0, a);
		op(1'b0, 1'b1, 1'b0, b);
	endtask
	task rreg(input logic [7:0] a);
		op(1'b1, 1'b0, 1'b0, a);
		op(1'b0, 1'b0, 1'b1, 8'h00);
		v = rdat;
	endtask
	task conv(input logic [10:0] lx, input logic [12:0] rx);
		lv = lx;
		rv = rx;
		req = ~req;
		repeat (30) @(posedge mclk_i);
		#1;
	endtask
	task tally_and_finish;
		$display("mismatches %0d of %0d comparisons", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (4) @(posedge mclk_i);
		#1;
		rst_n_i = 1'b1;
		chk("rate_o", rate, 2'h2);
		chk("cfg_outs", {stby, filt, dmod, pin, osa, cra}, 6'h18);
		chk("offset_o", offs, 11'h000);
		// pointer still selects the local integer
		conv(11'h2A5, 13'h0C40);
		op(1'b0, 1'b0, 1'b1, 8'h00);
		chk("ptr_reset", rdat, 8'h54);
		for (i = 0; i < 12; i++) begin
			rreg(ra[i]);
			chk("reset_val", v, rs[i]);
		end
		rreg(A_MAKER);
		chk("maker", v, 8'h5A);
		// random write-back through both aliases, unused bits read zero except bit 0 of the second config register, which reads one
		for (i = 0; i < 12; i++) begin
			d = 8'($random(seed));
			wreg(wa[i], d);
			sh[ra[i]] = (d & mk[i]) | ((ra[i] == A_CFG2) ? CFG2_ONES : 8'h00);
			rreg(ra[i]);
			chk("rw", v, sh[ra[i]]);
		end
		chk("stby", stby, sh[8'h03][6]);
		chk("rate", rate, sh[8'h04][1:0]);
		chk("offs", offs, {sh[8'h11], sh[8'h12][7:5]});
		chk("cfg2", {dmod, filt, pin}, {sh[8'hBF][3], &sh[8'hBF][2:1], sh[8'hBF][6]});
		// read-only and unlisted places ignore writes
		wreg(8'h02, 8'hFF);
		wreg(8'h05, 8'hFF);
		wreg(8'hFE, 8'h00);
		wreg(8'h31, 8'hAA);
		for (i = 0; i < 12; i++) begin
			rreg(ra[i]);
			chk("ro_write", v, sh[ra[i]]);
		end
		rreg(8'h05);
		chk("unlisted", v, 8'h00);
		for (i = 0; i < 12; i++) wreg(wa[i], rs[i]);
		// enable low freezes the bank: neither pointer nor data is taken
		ce = 1'b0;
		wreg(A_HYST, 8'h03);
		ce = 1'b1;
		rreg(A_HYST);
		chk("ce_hold", v, 8'h0A);
		// single conversion only while in standby
		s0 = starts;
		wreg(A_ONESHOT, 8'hA5);
		repeat (4) @(posedge mclk_i);
		s0 = starts - s0;
		chk("oneshot_run", s0[15:0], 16'h0000);
		wreg(A_CFG1, 8'h40);
		s0 = starts;
		wreg(A_ONESHOT, 8'h00);
		repeat (4) @(posedge mclk_i);
		s0 = starts - s0;
		chk("oneshot_stby", s0[15:0], 16'h0001);
		rreg(A_ONESHOT);
		chk("oneshot_rd", v, 8'h00);
		wreg(A_CFG1, 8'h00);
		// random temperatures under both filter settings, saturation first
		for (i = 0; i < 8; i++) begin
			wreg(A_CFG2, i[0] ? 8'h19 : 8'h1F);
			l = 11'($random(seed));
			r = 13'($random(seed));
			r[12] = (i < 2);
			conv(l, r);
			rreg(A_LOC_INT);
			chk("loc_int", v, l[10:3]);
			rreg(A_LOC_FRAC);
			chk("loc_frac", v, {l[2:0], 5'h00});
			rreg(A_REM_SINT);
			chk("rem_sint", v, r[12] ? SINT_MAX : r[12:5]);
			rreg(A_REM_SFRAC);
			chk("rem_sfrac", v, sfrac(r, ~i[0]));
			rreg(A_REM_UINT);
			chk("rem_uint", v, r[12:5]);
			rreg(A_REM_UFRAC);
			chk("rem_ufrac", v, ufrac(r, ~i[0]));
		end
		wreg(A_CFG2, 8'h1F);
		// fraction frozen by an integer read, refreshed by a later one
		conv(11'h123, 13'h0A51);
		rreg(A_LOC_INT);
		conv(11'h456, 13'h0B2E);
		rreg(A_LOC_FRAC);
		chk("frz_held", v, 8'h60);
		op(1'b0, 1'b0, 1'b1, 8'h00);
		chk("frz_free", rdat, 8'hC0);
		rreg(A_REM_UINT);
		conv(11'h456, 13'h0C0F);
		rreg(A_REM_UINT);
		chk("frz_reint", v, 8'h60);
		rreg(A_REM_UFRAC);
		chk("frz_refr", v, 8'h78);
		// diode fault readings and status flags
		flt = 1'b1;
		det = 1'b1;
		conv(11'h0C8, 13'h0320);
		rreg(A_REM_SINT);
		chk("flt_sint", v, SINT_FAULT);
		rreg(A_REM_UINT);
		chk("flt_uint", v, 8'hFF);
		rreg(A_STAT1);
		chk("st1_fault", v & 8'h04, 8'h04);
		rreg(A_STAT2);
		chk("st2_det", v, 8'h40);
		flt = 1'b0;
		det = 1'b0;
		nrdy = 1'b1;
		conv(11'h0C8, 13'h0320);
		rreg(A_STAT2);
		chk("st2_nrdy", v, 8'h80);
		nrdy = 1'b0;
		// alarms set above a limit, clear only below limit minus hysteresis
		for (i = 0; i < 8; i++) begin
			conv({lt[i], 3'h0}, {rt[i], 5'h00});
			chk("os_alarm", osa, eo[i]);
			chk("crit_alarm", cra, ec[i]);
			rreg(A_STAT1);
			chk("st1_cmp", v & 8'h13, st[i]);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
